// ### core/fe_cfg_map.svh
// Purpose: Register indices, byte addresses, field positions and reset values
// Assumes: Byte address is four times the register index
// Notes:   Definitions only
`ifndef FE_CFG_MAP_SVH
`define FE_CFG_MAP_SVH

`define IDX_TERM        8'h34
`define IDX_PWR         8'h35
`define IDX_PATH        8'h36
`define IDX_GAIN        8'h39
`define IDX_FILT        8'h3B
`define IDX_STAT        8'h3F
`define BYTE_ADDR(i)    ({2'h0, (i), 2'h0})

`define TERM_RES_LSB    0
`define TERM_PRESET_LSB 6
`define TERM_PRESET_EN  8
`define TERM_CHGAIN_EN  15
`define PWR_AMP_PDN     12
`define PATH_CW_SEL     8
`define FILT_HPF_LSB    2
`define FILT_ATT_LSB    4
`define FILT_ATT_EN     7
`define FILT_SUM_PWR    8
`define FILT_TEST_ROUTE 9

`define WMASK_TERM      16'h81FF
`define WMASK_PWR       16'h1000
`define WMASK_PATH      16'h0100
`define WMASK_GAIN      16'hFFFF
`define WMASK_FILT      16'h03FC

`define RST_TERM        16'h0000
`define RST_PWR         16'h0000
`define RST_PATH        16'h0000
`define RST_GAIN        16'h0000
`define RST_FILT        16'h0000

`define GAIN_18DB       2'h0
`define GAIN_24DB       2'h1
`define GAIN_12DB       2'h2
`define GAIN_RSVD       2'h3

`endif

// ### core/fe_cfg_pkg.sv
// Purpose: Types shared by the front-end configuration bank
// Assumes: Nothing beyond the map header
// Notes:   Types only
package fe_cfg_pkg;

    typedef logic [1:0] gain_code_t;
    typedef logic [4:0] term_set_t;

    typedef enum logic [2:0] {
        SEL_NONE, SEL_TERM, SEL_PWR, SEL_PATH, SEL_GAIN, SEL_FILT, SEL_STAT
    } reg_sel_t;

    typedef enum logic [0:0] {
        PH_IDLE, PH_RESP
    } apb_phase_t;

    typedef struct packed {
        gain_code_t [7:0] gain;
        term_set_t  [7:0] term;
    } chan_cfg_t;

    typedef struct packed {
        logic [1:0] hpfCorner;
        logic       attenEnable;
        logic [2:0] attenSteps;
        logic       summerRun;
        logic       testRoute;
        logic       pathCw;
        logic       ampPowerDown;
    } path_cfg_t;

endpackage

// ### core/term_decoder.sv
// Purpose: Resolves one channel's termination resistor set
// Assumes: Gain code already filtered of the reserved value
// Notes:   Pure combinational; the caller registers the result
`include "fe_cfg_map.svh"

module term_decoder
    import fe_cfg_pkg::*;
(
    input  wire gain_code_t gainCode,
    input  wire term_set_t  manualSet,
    input  wire logic       presetEn,
    input  wire logic [1:0] presetSel,
    output      term_set_t  termSet
);

    // Presets aim at nominal 50/100/200/400 ohm, nearest set per gain
    function automatic term_set_t presetLookup(gain_code_t g, logic [1:0] p);
        term_set_t s;
        s = 5'h00;
        case (g)
            `GAIN_24DB: begin
                case (p)
                    2'h0:    s = 5'h01;
                    2'h1:    s = 5'h02;
                    2'h2:    s = 5'h04;
                    default: s = 5'h08;
                endcase
            end
            `GAIN_12DB: begin
                case (p)
                    2'h0:    s = 5'h1F;
                    2'h1:    s = 5'h03;
                    2'h2:    s = 5'h06;
                    default: s = 5'h0C;
                endcase
            end
            default: begin
                case (p)
                    2'h0:    s = 5'h07;
                    2'h1:    s = 5'h0E;
                    2'h2:    s = 5'h02;
                    default: s = 5'h04;
                endcase
            end
        endcase
        return s;
    endfunction

    always_comb begin
        if (presetEn) begin
            termSet = presetLookup(gainCode, presetSel);
        end else begin
            termSet = manualSet;
        end
    end

endmodule

// ### core/frontend_gain_term_config.sv
// Purpose: APB register bank for preamp gain, filter, attenuator and termination
// Assumes: APB master holds the request until pready; one clock domain
// Notes:   Outputs lag a committed write by one clock
//
// Behaviour
// - Per-channel two-bit preamp gain codes stored
// - Channel gains apply only with enable bit
// - Two bits select preamp high-pass corner
// - Attenuation steps count only when enabled
// - One bit enables digital attenuator
// - Summer power bit honoured only in test with CW path off
// - Test bit routes amplifier onto doppler outputs
// - Five independent termination resistor enables
// - Bits map to 450..4500 ohm resistors
// - All-zero termination leaves input high impedance
// - Termination identical on both operating paths
// - Preset field picks resistor set by gain
// - Mode select does not power down amplifiers
`include "fe_cfg_map.svh"

module frontend_gain_term_config
    import fe_cfg_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output      logic        pready,
    output      logic [31:0] prdata,
    output      logic        pslverr,
    output      chan_cfg_t   chanCfg,
    output      path_cfg_t   pathCfg
);

    function automatic reg_sel_t decodeAddr(logic [11:0] a);
        reg_sel_t s;
        s = SEL_NONE;
        case (a)
            `BYTE_ADDR(`IDX_TERM): s = SEL_TERM;
            `BYTE_ADDR(`IDX_PWR):  s = SEL_PWR;
            `BYTE_ADDR(`IDX_PATH): s = SEL_PATH;
            `BYTE_ADDR(`IDX_GAIN): s = SEL_GAIN;
            `BYTE_ADDR(`IDX_FILT): s = SEL_FILT;
            `BYTE_ADDR(`IDX_STAT): s = SEL_STAT;
            default:               s = SEL_NONE;
        endcase
        return s;
    endfunction

    // Only the two low byte lanes carry register bits
    function automatic logic [15:0] mergeWrite(logic [15:0] old, logic [31:0] wd,
                                               logic [3:0] st, logic [15:0] msk);
        logic [15:0] m;
        m = msk & {{8{st[1]}}, {8{st[0]}}};
        return (old & ~m) | (wd[15:0] & m);
    endfunction

    apb_phase_t  phase_r,   phase_nxt;
    logic        pready_r,  pready_nxt;
    logic [31:0] prdata_r,  prdata_nxt;
    logic        pslverr_r, pslverr_nxt;
    logic [15:0] termReg_r, termReg_nxt;
    logic [15:0] pwrReg_r,  pwrReg_nxt;
    logic [15:0] pathReg_r, pathReg_nxt;
    logic [15:0] gainReg_r, gainReg_nxt;
    logic [15:0] filtReg_r, filtReg_nxt;
    chan_cfg_t   chanCfg_r, chanCfg_nxt;
    path_cfg_t   pathCfg_r, pathCfg_nxt;
    gain_code_t  [7:0] effGain;
    term_set_t   [7:0] termDec;
    logic        [7:0] rsvdSeen;
    logic [15:0] statusWord;
    reg_sel_t    sel;
    logic        accessCyc;
    logic        commitWr;

    assign sel       = decodeAddr(paddr);
    assign accessCyc = psel && penable;
    assign commitWr  = accessCyc && pready_r && pwrite && !pslverr_r;

    // APB slave: one wait state, answer registered so pready comes from a flop
    always_comb begin
        phase_nxt   = phase_r;
        pready_nxt  = 1'b0;
        prdata_nxt  = prdata_r;
        pslverr_nxt = 1'b0;
        case (phase_r)
            PH_IDLE: begin
                if (accessCyc) begin
                    phase_nxt   = PH_RESP;
                    pready_nxt  = 1'b1;
                    pslverr_nxt = (sel == SEL_NONE);
                    case (sel)
                        SEL_TERM: prdata_nxt = {16'h0000, termReg_r};
                        SEL_PWR:  prdata_nxt = {16'h0000, pwrReg_r};
                        SEL_PATH: prdata_nxt = {16'h0000, pathReg_r};
                        SEL_GAIN: prdata_nxt = {16'h0000, gainReg_r};
                        SEL_FILT: prdata_nxt = {16'h0000, filtReg_r};
                        SEL_STAT: prdata_nxt = {16'h0000, statusWord};
                        default:  prdata_nxt = 32'h0000_0000;
                    endcase
                end
            end
            PH_RESP: begin
                phase_nxt = PH_IDLE;
            end
            default: begin
                phase_nxt = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            phase_r   <= PH_IDLE;
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            phase_r   <= phase_nxt;
            pready_r  <= pready_nxt;
            prdata_r  <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // Register storage; writes land only at the completing edge
    always_comb begin
        termReg_nxt = termReg_r;
        pwrReg_nxt  = pwrReg_r;
        pathReg_nxt = pathReg_r;
        gainReg_nxt = gainReg_r;
        filtReg_nxt = filtReg_r;
        if (commitWr) begin
            case (sel)
                SEL_TERM: termReg_nxt = mergeWrite(termReg_r, pwdata, pstrb, `WMASK_TERM);
                SEL_PWR:  pwrReg_nxt  = mergeWrite(pwrReg_r,  pwdata, pstrb, `WMASK_PWR);
                SEL_PATH: pathReg_nxt = mergeWrite(pathReg_r, pwdata, pstrb, `WMASK_PATH);
                SEL_GAIN: gainReg_nxt = mergeWrite(gainReg_r, pwdata, pstrb, `WMASK_GAIN);
                SEL_FILT: filtReg_nxt = mergeWrite(filtReg_r, pwdata, pstrb, `WMASK_FILT);
                default:  termReg_nxt = termReg_r;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            termReg_r <= `RST_TERM;
            pwrReg_r  <= `RST_PWR;
            pathReg_r <= `RST_PATH;
            gainReg_r <= `RST_GAIN;
            filtReg_r <= `RST_FILT;
        end else begin
            termReg_r <= termReg_nxt;
            pwrReg_r  <= pwrReg_nxt;
            pathReg_r <= pathReg_nxt;
            gainReg_r <= gainReg_nxt;
            filtReg_r <= filtReg_nxt;
        end
    end

    // Reserved code falls back to 18 dB so the analog side never sees it
    genvar ch;
    generate
        for (ch = 0; ch < 8; ch++) begin : g_chan
            assign rsvdSeen[ch] = (gainReg_r[2*ch +: 2] == `GAIN_RSVD);
            assign effGain[ch]  = (termReg_r[`TERM_CHGAIN_EN] && !rsvdSeen[ch]) ?
                                  gainReg_r[2*ch +: 2] : `GAIN_18DB;
            // Path select is not an input here, so both paths share one set
            term_decoder u_term (
                .gainCode  (effGain[ch]),
                .manualSet (termReg_r[`TERM_RES_LSB +: 5]),
                .presetEn  (termReg_r[`TERM_PRESET_EN]),
                .presetSel (termReg_r[`TERM_PRESET_LSB +: 2]),
                .termSet   (termDec[ch])
            );
        end
    endgenerate

    assign statusWord = {6'h00, pathCfg_r.pathCw, termReg_r[`TERM_PRESET_EN], rsvdSeen};

    always_comb begin
        chanCfg_nxt.gain = effGain;
        chanCfg_nxt.term = termDec;
        pathCfg_nxt.hpfCorner   = filtReg_r[`FILT_HPF_LSB +: 2];
        pathCfg_nxt.attenEnable = filtReg_r[`FILT_ATT_EN];
        pathCfg_nxt.attenSteps  = filtReg_r[`FILT_ATT_EN] ?
                                  filtReg_r[`FILT_ATT_LSB +: 3] : 3'h0;
        pathCfg_nxt.testRoute   = filtReg_r[`FILT_TEST_ROUTE];
        pathCfg_nxt.pathCw      = pathReg_r[`PATH_CW_SEL];
        // Summer stays running unless the time-gain test route, with CW path off, asks otherwise
        pathCfg_nxt.summerRun   = (filtReg_r[`FILT_TEST_ROUTE] && !pathReg_r[`PATH_CW_SEL]) ?
                                  filtReg_r[`FILT_SUM_PWR] : 1'b1;
        pathCfg_nxt.ampPowerDown = pwrReg_r[`PWR_AMP_PDN];
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            chanCfg_r <= '0;
            pathCfg_r <= '{hpfCorner: 2'h0, attenEnable: 1'b0, attenSteps: 3'h0,
                           summerRun: 1'b1, testRoute: 1'b0, pathCw: 1'b0,
                           ampPowerDown: 1'b0};
        end else begin
            chanCfg_r <= chanCfg_nxt;
            pathCfg_r <= pathCfg_nxt;
        end
    end

    assign pready  = pready_r;
    assign prdata  = prdata_r;
    assign pslverr = pslverr_r;
    assign chanCfg = chanCfg_r;
    assign pathCfg = pathCfg_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_gain_code_map: assert property (
        termReg_r[15] && gainReg_r[5:4] != 2'h3 |=> chanCfg_r.gain[2] == $past(gainReg_r[5:4])
    ) else $error("channel 3 gain code not passed through");
    a_gain_ch8_map: assert property (
        termReg_r[15] && gainReg_r[15:14] != 2'h3 |=> chanCfg_r.gain[7] == $past(gainReg_r[15:14])
    ) else $error("channel 8 gain code not passed through");
    a_gain_write_lands: assert property (
        commitWr && sel == SEL_GAIN && pstrb[1:0] == 2'h3 |=> gainReg_r == $past(pwdata[15:0])
    ) else $error("gain write did not land");
    a_gain_gate_off: assert property (
        !termReg_r[15] |=> chanCfg_r.gain == '0
    ) else $error("channel gains applied without enable");
    a_hpf_corner: assert property (
        ##1 pathCfg_r.hpfCorner == $past(filtReg_r[3:2])
    ) else $error("high-pass corner mismatch");
    a_atten_gated: assert property (
        !filtReg_r[7] |=> pathCfg_r.attenSteps == 3'h0 && !pathCfg_r.attenEnable
    ) else $error("attenuation active while disabled");
    a_atten_enable: assert property (
        filtReg_r[7] |=> pathCfg_r.attenEnable && pathCfg_r.attenSteps == $past(filtReg_r[6:4])
    ) else $error("attenuator enable not honoured");
    a_summer_ignored: assert property (
        !(filtReg_r[9] && !pathReg_r[8]) |=> pathCfg_r.summerRun
    ) else $error("summer power bit honoured outside test");
    a_summer_honoured: assert property (
        filtReg_r[9] && !pathReg_r[8] |=> pathCfg_r.summerRun == $past(filtReg_r[8])
    ) else $error("summer power bit ignored in test");
    a_test_route: assert property (
        ##1 pathCfg_r.testRoute == $past(filtReg_r[9])
    ) else $error("test route bit not followed");
    a_term_manual: assert property (
        !termReg_r[8] |=> chanCfg_r.term[0] == $past(termReg_r[4:0])
                          && chanCfg_r.term[7] == $past(termReg_r[4:0])
    ) else $error("manual termination set mismatch");
    a_term_write_mask: assert property (
        commitWr && sel == SEL_TERM && pstrb[1:0] == 2'h3
        |=> termReg_r == ($past(pwdata[15:0]) & `WMASK_TERM)
    ) else $error("termination write mask wrong");
    a_term_highz: assert property (
        !termReg_r[8] && termReg_r[4:0] == 5'h00 |=> chanCfg_r.term == '0
    ) else $error("resistor enabled with all bits clear");
    a_term_path_free: assert property (
        $changed(pathReg_r) && $stable(termReg_r) && $stable(gainReg_r)
        |=> ##1 $stable(chanCfg_r.term)
    ) else $error("termination moved with path change");
    a_term_shared: assert property (
        !termReg_r[8] |=> chanCfg_r.term == {8{$past(termReg_r[4:0])}}
    ) else $error("channels differ in manual termination");
    a_term_preset: assert property (
        termReg_r[8] |=> chanCfg_r.term[0] != 5'h00
    ) else $error("preset left input unterminated");
    a_preset_12db: assert property (
        termReg_r[15] && termReg_r[8] && termReg_r[7:6] == 2'h3 && gainReg_r[1:0] == 2'h2
        |=> chanCfg_r.term[0] == 5'h0C
    ) else $error("12 dB preset set wrong");
    a_amp_pdn_sep: assert property (
        ##1 pathCfg_r.ampPowerDown == $past(pwrReg_r[12])
    ) else $error("amplifier power-down tied to mode");
    a_amp_pdn_path: assert property (
        $rose(pathReg_r[8]) && !pwrReg_r[12] |=> !pathCfg_r.ampPowerDown
    ) else $error("path select powered amplifiers down");
    // Bus handshake: a refused access must answer on time and touch no register
    a_apb_answer: assert property (
        accessCyc && !pready_r |=> pready_r ##1 !pready_r
    ) else $error("APB answer not after one wait state");
    a_err_answer: assert property (
        accessCyc && !pready_r && sel == SEL_NONE |=> pready_r && pslverr_r
    ) else $error("unmapped access not refused");
    a_err_no_write: assert property (
        accessCyc && pready_r && pslverr_r
        |=> $stable(termReg_r) && $stable(gainReg_r) && $stable(filtReg_r)
    ) else $error("refused write changed a register");
    a_ready_pulse: assert property (
        pready_r |=> !pready_r
    ) else $error("pready held beyond one cycle");
    a_ready_in_access: assert property (
        pready_r |-> accessCyc
    ) else $error("pready outside an access phase");
    a_rdata_upper: assert property (
        pready_r |-> prdata_r[31:16] == 16'h0000
    ) else $error("read data upper half not zero");

    c_write_done: cover property (commitWr ##4 commitWr);
    c_read_stat:  cover property (accessCyc && pready_r && !pwrite && sel == SEL_STAT);
    c_unmapped:   cover property (pslverr_r && accessCyc);
    c_preset_on:  cover property (termReg_r[8] && termReg_r[15]);
    c_summer_off: cover property (filtReg_r[9] && !pathReg_r[8] && !filtReg_r[8]);

endmodule

// ### test/tb_top.sv
// Purpose: Self-checking bench for the front-end configuration bank over APB
// Assumes: One wait state per access; outputs lag a commit by one clock
// Notes:   Register reads and port outputs are checked against inline expected values and a local preset table
`include "fe_cfg_map.svh"

module tb_top
    import fe_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [11:0] A_TERM = `BYTE_ADDR(`IDX_TERM);
    localparam logic [11:0] A_PWR  = `BYTE_ADDR(`IDX_PWR);
    localparam logic [11:0] A_PATH = `BYTE_ADDR(`IDX_PATH);
    localparam logic [11:0] A_GAIN = `BYTE_ADDR(`IDX_GAIN);
    localparam logic [11:0] A_FILT = `BYTE_ADDR(`IDX_FILT);
    localparam logic [11:0] A_STAT = `BYTE_ADDR(`IDX_STAT);
    // Preset sets by gain code (18, 24, 12 dB) and preset index
    localparam logic [4:0] PS [3][4] = '{'{5'h07, 5'h0E, 5'h02, 5'h04},
                                         '{5'h01, 5'h02, 5'h04, 5'h08},
                                         '{5'h1F, 5'h03, 5'h06, 5'h0C}};

    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [3:0]  pstrb   = 4'h0;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    chan_cfg_t   chanCfg;
    path_cfg_t   pathCfg;
    int          fails;
    int          cmp_count;

    frontend_gain_term_config dut (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pstrb   (pstrb),
        .pready  (pready),
        .prdata  (prdata),
        .pslverr (pslverr),
        .chanCfg (chanCfg),
        .pathCfg (pathCfg)
    );

    always #25 clk_sys = ~clk_sys;

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s flag %b", $time, what, got);
        end
    endtask

    // Request held until pready is sampled high; a hang is cut after 20 edges
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r, output logic e);
        int n;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk_flag(pready, 1'b1, "pready");
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, s, r, e);
        chk_flag(e, 1'b0, "write error");
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, 4'h0, r, e);
        chk_flag(e, 1'b0, "read error");
        chk(64'(r), 64'(exp), "read data");
    endtask

    task automatic bad(input logic w, input logic [11:0] a);
        logic [31:0] r;
        logic        e;
        apb(w, a, 32'h0000_001F, 4'hF, r, e);
        chk_flag(e, 1'b1, "refusal");
        if (!w) chk(64'(r), 64'h0, "refused data");
    endtask

    // Outputs follow the committed register one clock later
    task automatic settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic chk_term(input logic [4:0] v);
        for (int k = 0; k < 8; k++) chk(64'(chanCfg.term[k]), 64'(v), "term");
    endtask

    initial begin
        // Tests need under 500 clocks; ample margin, still far below any limit
        repeat (3000) @(posedge clk_sys);
        fails++;
        $display("[FAIL] %0t watchdog expired", $time);
        stop_test();
    end

    initial begin
        logic [4:0] v;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1;
        chk(64'(chanCfg), 64'h0, "reset chan");
        chk(64'(pathCfg), 64'h008, "reset path");
        rd(A_TERM, 32'h0);
        rd(A_GAIN, 32'h0);
        rd(A_FILT, 32'h0);
        rd(A_PWR, 32'h0);
        rd(A_PATH, 32'h0);
        rd(A_STAT, 32'h0);
        $display("test reset done");

        wr(A_GAIN, 32'h0000_9999);
        settle();
        chk(64'(chanCfg.gain), 64'h0, "gain gated");
        wr(A_TERM, 32'h0000_8000);
        settle();
        for (int k = 0; k < 8; k++) chk(64'(chanCfg.gain[k]), (k % 2) ? 64'h2 : 64'h1, "gain");
        // Software never writes the reserved code, so only legal codes go out
        wr(A_GAIN, 32'h0000_8000);
        settle();
        chk(64'(chanCfg.gain), 64'h8000, "ch8 gain");
        rd(A_STAT, 32'h0000_0000);
        $display("test gain done");

        for (int i = 0; i < 7; i++) begin
            v = (i < 5) ? 5'(1 << i) : ((i == 5) ? 5'h00 : 5'h1F);
            wr(A_TERM, 32'h0000_8000 | 32'(v));
            settle();
            chk_term(v);
        end
        $display("test manual term done");

        for (int c = 0; c < 3; c++) begin
            wr(A_GAIN, 32'({8{2'(c)}}));
            for (int p = 0; p < 4; p++) begin
                wr(A_TERM, 32'h0000_811F | 32'(p << 6));
                settle();
                chk_term(PS[c][p]);
            end
        end
        rd(A_STAT, 32'h0000_0100);
        $display("test preset done");

        wr(A_PATH, 32'h0000_FFFF);
        settle();
        chk_term(5'h0C);
        chk(64'(pathCfg.pathCw), 64'h1, "cw path");
        chk(64'(pathCfg.ampPowerDown), 64'h0, "amp power");
        rd(A_PATH, 32'h0000_0100);
        rd(A_STAT, 32'h0000_0300);
        wr(A_PWR, 32'h0000_FFFF);
        settle();
        chk(64'(pathCfg.ampPowerDown), 64'h1, "amp power");
        rd(A_PWR, 32'h0000_1000);
        $display("test path done");

        for (int h = 0; h < 4; h++) begin
            wr(A_FILT, 32'(h << 2));
            settle();
            chk(64'(pathCfg.hpfCorner), 64'(h), "hpf");
        end
        for (int s = 0; s < 8; s++) begin
            wr(A_FILT, 32'h0000_0080 | 32'(s << 4));
            settle();
            chk(64'(pathCfg.attenEnable), 64'h1, "atten en");
            chk(64'(pathCfg.attenSteps), 64'(s), "atten steps");
        end
        wr(A_FILT, 32'h0000_0200);
        settle();
        chk(64'(pathCfg.attenEnable), 64'h0, "atten off");
        chk(64'(pathCfg.summerRun), 64'h1, "summer in cw");
        wr(A_PATH, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            wr(A_FILT, 32'(i << 8));
            settle();
            chk(64'(pathCfg.summerRun), (i == 2) ? 64'h0 : 64'h1, "summer");
            chk(64'(pathCfg.testRoute), 64'(i >> 1), "route");
        end
        $display("test filter done");

        wr(A_FILT, 32'h0000_FFFF);
        rd(A_FILT, 32'h0000_03FC);
        wr(A_TERM, 32'h0000_FFFF);
        rd(A_TERM, 32'h0000_81FF);
        bad(1'b1, 12'h100);
        bad(1'b0, 12'h100);
        bad(1'b1, A_TERM | 12'h001);
        rd(A_TERM, 32'h0000_81FF);
        wr(A_STAT, 32'h0000_FFFF);
        wr(A_GAIN, 32'h0000_0000);
        wr(A_GAIN, 32'h0000_AAAA, 4'h1);
        rd(A_GAIN, 32'h0000_00AA);
        wr(A_GAIN, 32'h0000_5555, 4'h2);
        rd(A_GAIN, 32'h0000_55AA);
        $display("test access done");

        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1;
        chk(64'(chanCfg), 64'h0, "rerun chan");
        chk(64'(pathCfg), 64'h008, "rerun path");
        rd(A_TERM, 32'h0);
        rd(A_GAIN, 32'h0);
        rd(A_FILT, 32'h0);
        $display("test second reset done");
        stop_test();
    end
endmodule
